// File: rtl/fbo_host.sv
// Purpose: Host-side bus controller driving a byte-wide parallel flash
// Assumes: One request at a time, taken on req_valid with req_ready high; the unprotect exit is taken on req_valid with OP_UNPROT_X, without req_ready
// Notes:   Status polling and command sequences are built by the caller
`timescale 1ns/1ns
module fbo_host
  import fbo_pkg::*;
#(
  parameter int unsigned SEL_CYC   = SEL_ACCESS_CYC,
  parameter int unsigned CLR_CYC   = CLEAR_PULSE_CYC,
  parameter int unsigned WR_CYC    = WRITE_PULSE_CYC,
  parameter int unsigned SET_CYC   = SETUP_CYC,
  parameter bit          HAS_CLEAR = 1'b1
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              req_valid,
  input  wire fbo_req_type       req,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  output logic                   replay_pending,
  output logic                   chip_select_n,
  output logic                   output_gate_n,
  output logic                   write_strobe_n,
  output logic                   hard_clear_n,
  output logic                   high_voltage_level,
  output logic [ADDR_W-1:0]      addr_lines,
  input  wire logic [DATA_W-1:0] data_lines_in,
  output logic [DATA_W-1:0]      data_lines_out,
  output logic                   data_lines_oe
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD, ST_CLEAR,
    ST_UNPROT
  } fbo_state_type;

  fbo_state_type     state_reg;
  fbo_req_type       cur_reg;
  fbo_req_type       last_wr_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic [DATA_W-1:0] rd_sync;
  logic              write_seen_reg;

  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = CNT_W'((n < 1) ? 0 : n - 1);
  endfunction : cyc

  fbo_sync #(
    .W (DATA_W)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din     (data_lines_in),
    .dout    (rd_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      cur_reg   <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (req_valid && req_ready) begin
            cur_reg <= req;
            case (req.op)
              OP_READ: begin
                state_reg <= ST_RD;
                // Pin register, three sync stages, filter and capture
                // edge all sit after the access time, so six extra
                cnt_reg   <= cyc(SEL_CYC + 6);
              end
              OP_WRITE: begin
                state_reg <= ST_WR_SETUP;
                cnt_reg   <= cyc(SET_CYC);
              end
              OP_CLEAR: begin
                state_reg <= HAS_CLEAR ? ST_CLEAR : ST_IDLE;
                cnt_reg   <= cyc(CLR_CYC);
              end
              OP_UNPROT: begin
                state_reg <= HAS_CLEAR ? ST_UNPROT : ST_IDLE;
              end
              default: begin
                state_reg <= ST_IDLE;
              end
            endcase
          end
        end
        ST_RD, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD, ST_CLEAR: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - CNT_W'(1);
          end else begin
            case (state_reg)
              ST_WR_SETUP: begin
                state_reg <= ST_WR_PULSE;
                cnt_reg   <= cyc(WR_CYC);
              end
              ST_WR_PULSE: begin
                state_reg <= ST_WR_HOLD;
                cnt_reg   <= cyc(SET_CYC);
              end
              default: begin
                state_reg <= ST_IDLE;
              end
            endcase
          end
        end
        ST_UNPROT: begin
          // Only the exit request is honoured while unprotect is held
          if (req_valid && req.op == OP_UNPROT_X) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chip_select_n      <= 1'b1;
      output_gate_n      <= 1'b1;
      write_strobe_n     <= 1'b1;
      hard_clear_n       <= 1'b1;
      high_voltage_level <= 1'b0;
      addr_lines         <= '0;
      data_lines_out     <= '0;
      data_lines_oe      <= 1'b0;
    end else begin
      hard_clear_n       <= !(state_reg == ST_CLEAR);
      high_voltage_level <= (state_reg == ST_UNPROT);
      addr_lines         <= cur_reg.addr;
      data_lines_out     <= cur_reg.data;
      // Idle select high with clear high gives device standby
      chip_select_n      <= !(state_reg == ST_RD ||
                              state_reg == ST_WR_SETUP ||
                              state_reg == ST_WR_PULSE ||
                              state_reg == ST_WR_HOLD);
      output_gate_n      <= !(state_reg == ST_RD);
      write_strobe_n     <= !(state_reg == ST_WR_PULSE);
      // Host drives data only with gate high, so no contention
      data_lines_oe      <= (state_reg == ST_WR_SETUP ||
                             state_reg == ST_WR_PULSE ||
                             state_reg == ST_WR_HOLD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handshake and read return
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end else begin
      req_ready <= (state_reg == ST_IDLE) && !(req_valid && req_ready);
      // Array, id or status byte: same read timing for all
      rsp_valid <= (state_reg == ST_RD && cnt_reg == '0);
      if (state_reg == ST_RD && cnt_reg == '0) begin
        rsp_data <= rd_sync;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags at the end of a clear any write finished since the last clear, cut short or not, so the caller can replay it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      last_wr_reg    <= '0;
      write_seen_reg <= 1'b0;
      replay_pending <= 1'b0;
    end else begin
      if (state_reg == ST_WR_HOLD && cnt_reg == '0) begin
        last_wr_reg    <= cur_reg;
        write_seen_reg <= 1'b1;
      end
      if (state_reg == ST_CLEAR && cnt_reg == '0) begin
        replay_pending <= write_seen_reg;
        write_seen_reg <= 1'b0;
      end else if (req_valid && req_ready && req.op == OP_WRITE) begin
        replay_pending <= 1'b0;
      end
    end
  end

endmodule : fbo_host

// File: rtl/fbo_pkg.sv
// Purpose: Shared constants and types for the flash bus host controller
// Assumes: 100 MHz ref_clk
// Notes:   Device timing figures are plain defaults, not a speed grade
package fbo_pkg;

  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned ADDR_W             = 18;
  localparam int unsigned DATA_W             = 8;
  localparam int unsigned SECTOR_W           = 5;
  // Select access time and clear pulse minimum, in ns
  localparam int unsigned SEL_ACCESS_NS      = 120;
  localparam int unsigned CLEAR_PULSE_MIN_NS = 500;
  localparam int unsigned WRITE_PULSE_NS     = 50;
  localparam int unsigned SETUP_NS           = 20;
  // Least times round up to whole cycles
  localparam int unsigned SEL_ACCESS_CYC =
    (SEL_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CLEAR_PULSE_CYC =
    (CLEAR_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_PULSE_CYC =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC =
    (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;

  // Host command codes
  localparam logic [2:0] OP_READ     = 3'h0;
  localparam logic [2:0] OP_WRITE    = 3'h1;
  localparam logic [2:0] OP_CLEAR    = 3'h2;
  localparam logic [2:0] OP_UNPROT   = 3'h3;
  localparam logic [2:0] OP_UNPROT_X = 3'h4;

  typedef struct packed {
    logic [2:0]        op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fbo_req_type;

  typedef struct packed {
    logic              sel_n;
    logic              gate_n;
    logic              wr_n;
    logic              clear_n;
    logic              hv_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic              doe;
  } fbo_pins_type;

endpackage : fbo_pkg

// File: rtl/fbo_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Input asynchronous to ref_clk
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ns
module fbo_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Per-bit agreement keeps a bit at its last stable value
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule : fbo_sync

// File: verif/fbo_chk_assertions.sv
// Purpose: Pin rules the host keeps on the flash bus
// Assumes: One ref_clk domain, rst_n synchronous active low
// Notes:   Bound to fbo_host below
`timescale 1ns/1ns
module fbo_chk
  import fbo_pkg::*;
#(
  parameter int unsigned CLR_CYC = CLEAR_PULSE_CYC
) (
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              rsp_valid,
  input wire logic              chip_select_n,
  input wire logic              output_gate_n,
  input wire logic              write_strobe_n,
  input wire logic              hard_clear_n,
  input wire logic              high_voltage_level,
  input wire logic [ADDR_W-1:0] addr_lines,
  input wire logic [DATA_W-1:0] data_lines_out,
  input wire logic              data_lines_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] clr_cnt_reg;
  ////////////////////////////////////////////////////////////////////////////
  // Saturates so a long clear cannot wrap
  always_ff @(posedge ref_clk) begin
    if (!rst_n || hard_clear_n) clr_cnt_reg <= 8'h00;
    else if (clr_cnt_reg != 8'hFF) clr_cnt_reg <= clr_cnt_reg + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_read_lvl;
    !output_gate_n |-> write_strobe_n && !chip_select_n && !data_lines_oe;
  endproperty
  a_read_lvl:
    assert property (p_read_lvl) else $error("read pin levels wrong");
  property p_read_hold;
    $fell(output_gate_n) |=> (!output_gate_n && $stable(addr_lines))[*7];
  endproperty
  a_read_hold:
    assert property (p_read_hold) else $error("read cut short");
  property p_wr_lvl;
    !write_strobe_n |-> !chip_select_n && output_gate_n && data_lines_oe;
  endproperty
  a_wr_lvl:
    assert property (p_wr_lvl) else $error("write pin levels wrong");
  property p_wr_hold;
    !write_strobe_n && $past(!write_strobe_n)
      |-> $stable(addr_lines) && $stable(data_lines_out);
  endproperty
  a_wr_hold:
    assert property (p_wr_hold) else $error("write bus moved");
  property p_clr_len;
    $rose(hard_clear_n) |-> clr_cnt_reg >= CLR_CYC;
  endproperty
  a_clr_len:
    assert property (p_clr_len) else $error("clear pulse too short");
  property p_hv_clr;
    high_voltage_level |-> hard_clear_n;
  endproperty
  a_hv_clr:
    assert property (p_hv_clr) else $error("clear low at high level");
  c_read: cover property (rsp_valid);
  c_write: cover property ($fell(write_strobe_n));
  c_clear: cover property ($fell(hard_clear_n));
  c_unprot: cover property ($rose(high_voltage_level));
endmodule : fbo_chk

bind fbo_host fbo_chk u_chk (
  .ref_clk, .rst_n, .rsp_valid, .chip_select_n, .output_gate_n,
  .write_strobe_n, .hard_clear_n, .high_voltage_level, .addr_lines,
  .data_lines_out, .data_lines_oe
);

// File: verif/fbo_flash_model.sv
// Purpose: Behavioural byte-wide flash on the far side of the bus
// Assumes: Pins arrive as fbo_pins_type
// Notes:   Command codes are this model's own, not a real set
`timescale 1ns/1ns
module fbo_flash_model
  import fbo_pkg::*;
#(
  parameter logic [7:0] ID_CODE = 8'h3C, // Arbitrary value
  parameter int         BUSY_NS = 2000
) (
  input  wire fbo_pins_type pins,
  output logic [7:0]        dq
);
  logic [7:0] mem [logic [ADDR_W-1:0]];
  logic [7:0] last = 8'h00, pdat = 8'h00;
  logic [ADDR_W-1:0] padr = '0;
  logic id_mode = 1'b0, arm = 1'b0, busy = 1'b0, acc_ok = 1'b0, era = 1'b0;
  wire drive = !pins.sel_n && !pins.gate_n && pins.wr_n && pins.clear_n
               && !pins.hv_en && acc_ok;
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge pins.sel_n) begin
    acc_ok = 1'b0;
    #(SEL_ACCESS_NS);
    acc_ok = !pins.sel_n;
  end
  always @(posedge pins.sel_n) acc_ok = 1'b0;
  // Latches hidden from the address map
  always @(posedge pins.wr_n) begin
    if (!pins.sel_n && pins.gate_n && pins.clear_n && !pins.hv_en) begin
      if (arm) begin
        arm = 1'b0;
        padr = pins.addr;
        pdat = pins.dout;
        busy = 1'b1;
      end
      else if (era) begin
        era = 1'b0;
        foreach (mem[k])
          if (k[ADDR_W-1 -: SECTOR_W] == pins.addr[ADDR_W-1 -: SECTOR_W])
            mem[k] = 8'hFF;
      end
      else if (pins.dout == 8'h80) era = 1'b1;
      else if (pins.dout == 8'hA0) arm = 1'b1;
      else if (pins.dout == 8'h90) id_mode = 1'b1;
      else if (pins.dout == 8'hF0) id_mode = 1'b0;
    end
  end
  // Runs on whether selected or not
  always @(posedge busy) begin
    #(BUSY_NS);
    if (busy) mem[padr] = pdat;
    busy = 1'b0;
  end
  always @(negedge pins.clear_n) begin
    busy = 1'b0;
    arm = 1'b0;
    era = 1'b0;
    id_mode = 1'b0;
  end
  always @* begin
    if (!drive) dq = ~last;
    else if (busy) dq = {~pdat[7], 7'h00};
    else if (id_mode) dq = ID_CODE;
    else dq = mem.exists(pins.addr) ? mem[pins.addr] : 8'hFF;
    if (drive) last = dq;
  end
endmodule : fbo_flash_model

// File: verif/fbo_host_test.sv
// Purpose: Self-checking bench for fbo_host with a flash model
// Assumes: Inputs change on the falling edge
// Notes:   Clear pulse kept at its full minimum length
`timescale 1ns/1ns
module fbo_host_test
  import fbo_pkg::*;
;
  logic ref_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
  fbo_req_type req = '0;
  logic req_ready, rsp_valid, replay_pending, chip_select_n, output_gate_n;
  logic write_strobe_n, hard_clear_n, high_voltage_level, data_lines_oe;
  logic [ADDR_W-1:0] addr_lines;
  logic [7:0] rsp_data, data_lines_out, data_lines_in, dq;
  fbo_pins_type pins;
  int fails = 0, samples_checked = 0;
  always #5 ref_clk = ~ref_clk;
  assign pins = {chip_select_n, output_gate_n, write_strobe_n, hard_clear_n,
                 high_voltage_level, addr_lines, data_lines_out, data_lines_oe};
  assign data_lines_in = data_lines_oe ? data_lines_out : dq;
  fbo_host dut (.ref_clk, .rst_n, .req_valid, .req,
    .req_ready, .rsp_valid, .rsp_data, .replay_pending, .chip_select_n,
    .output_gate_n, .write_strobe_n, .hard_clear_n, .high_voltage_level,
    .addr_lines, .data_lines_in, .data_lines_out, .data_lines_oe);
  fbo_flash_model u_dev (.pins, .dq);
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [7:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Bounded wait for a level; a hang ends the run
  task automatic wait_lvl(ref logic sig, input logic lvl);
    int n;
    n = 0;
    while (sig !== lvl && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 300) begin
      fails++;
      end_of_test();
    end
  endtask : wait_lvl
  task automatic xfer(input logic [2:0] op, input logic [ADDR_W-1:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    req_valid = 1'b1;
    req = '{op, a, d};
    wait_lvl(req_ready, 1'b1);
    @(negedge ref_clk);
    req_valid = 1'b0;
    @(negedge ref_clk);
    if (op == OP_READ) wait_lvl(rsp_valid, 1'b1);
    q = rsp_data;
    if (op != OP_UNPROT) wait_lvl(req_ready, 1'b1);
  endtask : xfer
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_program;
    logic [7:0] q;
    int n;
    xfer(OP_READ, 18'h12345, 8'h00, q);
    chk("boot read", 8'hFF, q);
    xfer(OP_WRITE, 18'h00555, 8'hA0, q);
    xfer(OP_WRITE, 18'h20010, 8'h5C, q);
    xfer(OP_READ, 18'h20010, 8'h00, q);
    chk("busy status", 8'h80, q);
    for (n = 0; n < 40 && q !== 8'h5C; n++) xfer(OP_READ, 18'h20010, 8'h00, q);
    chk("programmed", 8'h5C, q);
  endtask : t_program
  task automatic t_ident;
    logic [7:0] q;
    xfer(OP_WRITE, 18'h00555, 8'h90, q);
    xfer(OP_READ, 18'h20010, 8'h00, q);
    chk("ident code", 8'h3C, q);
    xfer(OP_WRITE, 18'h00000, 8'hF0, q);
    xfer(OP_READ, 18'h20010, 8'h00, q);
    chk("array again", 8'h5C, q);
  endtask : t_ident
  task automatic t_clear;
    logic [7:0] q;
    xfer(OP_WRITE, 18'h00555, 8'hA0, q);
    xfer(OP_WRITE, 18'h3A000, 8'h33, q);
    xfer(OP_CLEAR, 18'h00000, 8'h00, q);
    chk("replay set", 8'h01, {7'h00, replay_pending});
    xfer(OP_READ, 18'h3A000, 8'h00, q);
    chk("aborted", 8'hFF, q);
    xfer(OP_WRITE, 18'h00000, 8'hF0, q);
    chk("replay gone", 8'h00, {7'h00, replay_pending});
  endtask : t_clear
  task automatic t_unprot;
    logic [7:0] q;
    xfer(OP_UNPROT, 18'h00000, 8'h00, q);
    wait_lvl(high_voltage_level, 1'b1);
    chk("hv clear", 8'h01, {7'h00, hard_clear_n});
    req_valid = 1'b1;
    req.op = OP_UNPROT_X;
    wait_lvl(high_voltage_level, 1'b0);
    req_valid = 1'b0;
    wait_lvl(req_ready, 1'b1);
    xfer(OP_READ, 18'h20010, 8'h00, q);
    chk("after unprot", 8'h5C, q);
    xfer(OP_WRITE, 18'h00555, 8'h80, q);
    xfer(OP_WRITE, 18'h20000, 8'h30, q);
    xfer(OP_READ, 18'h20010, 8'h00, q);
    chk("sector erased", 8'hFF, q);
  endtask : t_unprot
  initial begin
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    t_program();
    t_ident();
    t_clear();
    t_unprot();
    end_of_test();
  end
endmodule : fbo_host_test
